// file: sfa_pkg.sv
package sfa_pkg;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef logic [7:0] sfa_byte_t;
  typedef logic [3:0] sfa_code_t;
  typedef enum logic [2:0] {
    FLD_IDLE = 3'b000,
    FLD_CTRL = 3'b001,
    FLD_LEN  = 3'b010,
    FLD_DATA = 3'b011,
    FLD_HALT = 3'b100
  } sfa_field_e;

  // ---------------------------------------------------------------
  // Field layout and bit timing
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_W = 4'h4;
  localparam logic [3:0] BYTE_W = 4'h8;
  localparam logic ACK = 1'b0;
  localparam logic NACK = 1'b1;
  localparam int BIT_CYC = 4;
  localparam logic [2:0] TICK_LAST = 3'(BIT_CYC - 1);
  localparam logic [8:0] LEFT_ONE = 9'h001;

  // ---------------------------------------------------------------
  // Control codes
  // ---------------------------------------------------------------
  localparam sfa_code_t CC_STATUS = 4'h0;
  localparam sfa_code_t CC_RD_LOCK = 4'h3;
  localparam sfa_code_t CC_LKA_LO = 4'h4;
  localparam sfa_code_t CC_LKA_HI = 4'h5;
  localparam sfa_code_t CC_STAT_UNLK = 4'h6;
  localparam sfa_code_t CC_RD_DATA = 4'h7;
  localparam sfa_code_t CC_WC_LOCK = 4'hA;
  localparam sfa_code_t CC_WD_LOCK = 4'hB;
  localparam sfa_code_t CC_WR_CMD = 4'hE;
  localparam sfa_code_t CC_WR_DATA = 4'hF;

  // ---------------------------------------------------------------
  // Controller register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TXD = 4'h4;
  localparam logic [3:0] REG_RXD = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam int CTRL_BCAST_BIT = 4;
  localparam int CTRL_GO_BIT = 16;

  // Length byte to byte count, where zero stands for 256.
  function automatic logic [8:0] sfa_len_count(input sfa_byte_t len);
    return {~|len, len};
  endfunction

endpackage

// file: sfa_link_if.sv
interface sfa_link_if;
  logic frame;
  logic sync;
  logic m_o;
  logic m_oe;
  logic s_o;
  logic s_oe;
  logic line;

  // Wired-AND bus: an undriven line reads one.
  assign line = (m_oe ? m_o : 1'b1) & (s_oe ? s_o : 1'b1);

  modport master (output frame, output sync, output m_o, output m_oe,
                  input line);
  modport slave (input frame, input sync, input line, output s_o,
                 output s_oe);
endinterface

// file: sfa_slave_end.sv
// Summary of operation
// - Unlocked target acks 0,6; 3,7 with transmit; A,B,E,F with receive.
// - Anything else or untargeted gets negative ack.
// - Length byte counts data, zero means 256.
// - Written length: even parity acks, broadcast nacks.
// - Read length: slave sends, master acks even.
// - Written byte acked if even and buffer empty.
// - Master resends byte after nack within limit.
// - Broadcast slave stops on odd parity or full.
// - Master pulses sync per bit, slave answers.
// - Reading master nacks and rereads bad bytes.
// - Never start a broadcast master read.
// - Parity bit makes one count even.
// - Parity follows each field, then acknowledge.
// - Ack zero accepts, one refuses; broadcast ignores.
// - Address ack negative on error or absence.
// - Write code nacked when receive disabled.
// - Read data nacked when transmit disabled.
// - Locked slave refuses others' locking codes.
// - Unlocked slave refuses lock address reads.
// - Timing error or undefined code gets nack.
// - Slave status request is acked whatever the lock and enables.
// - Receive disable leaves broadcast reception running.
// - Control bit 3 sets length and data direction.
module sfa_slave_end (
  sfa_link_if.slave link,
  input wire logic mclk,
  input wire logic rst,
  input wire logic broadcast_flag,
  input wire logic targeted_request_flag,
  input wire logic locked,
  input wire logic lock_owner_match,
  input wire logic slave_tx_enable,
  input wire logic slave_rx_enable,
  input wire logic timing_error,
  input wire sfa_pkg::sfa_byte_t tx_len,
  input wire sfa_pkg::sfa_byte_t tx_data,
  input wire logic rx_taken,
  output sfa_pkg::sfa_byte_t byte_buffer,
  output logic rx_full,
  output logic data_request_irq,
  output logic transfer_end_irq
);
  import sfa_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sfa_field_e field_ff, nxt_field;
  logic [3:0] pos_ff, nxt_pos;
  logic pty_ff, nxt_pty;
  logic ok_ff, nxt_ok;
  logic ack_ff, nxt_ack;
  logic dir_wr_ff, nxt_dir_wr;
  logic bcast_ff, nxt_bcast;
  sfa_byte_t sr_ff, nxt_sr;
  sfa_byte_t tx_ff, nxt_tx;
  sfa_byte_t buf_ff, nxt_buf;
  logic [8:0] left_ff, nxt_left;
  logic full_set;
  logic req_ff, nxt_req;
  logic end_ff, nxt_end;
  logic frame_d_ff;
  logic full_ff;
  logic s_o_ff;
  logic s_oe_ff;
  logic code_ok;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire start = link.frame & ~frame_d_ff;
  wire live = (field_ff != FLD_IDLE) && (field_ff != FLD_HALT);
  wire [3:0] fw = (field_ff == FLD_CTRL) ? CTRL_W : BYTE_W;
  wire at_data = pos_ff < fw;
  wire at_par = pos_ff == fw;
  wire at_ack = pos_ff == (fw + 4'd1);
  wire bit_in = link.line;
  wire pty_ok = ~(pty_ff ^ bit_in);
  wire i_send = ((field_ff == FLD_LEN) || (field_ff == FLD_DATA)) &&
                !dir_wr_ff;
  wire lock_ok = ~locked | lock_owner_match;
  wire indiv = ~broadcast_flag & targeted_request_flag;
  wire ctrl_ack = pty_ok & ~timing_error & indiv & code_ok;
  wire bc_go = bcast_ff & ~locked & pty_ok & ~timing_error &
               sr_ff[3] & sr_ff[1];
  wire rx_ok = pty_ok & ~timing_error;
  wire take = rx_ok & ~full_ff;
  wire last = left_ff == LEFT_ONE;
  wire [2:0] bit_ix = 3'(4'd7 - pos_ff);
  wire drv_data = live & i_send & (at_data | at_par);
  wire drv_ack = live & ~i_send & ~bcast_ff & at_ack;
  wire drv_bit = at_par ? ^tx_ff : tx_ff[bit_ix];

  // ---------------------------------------------------------------
  // Control code acceptance
  // ---------------------------------------------------------------
  always_comb begin
    unique case (sr_ff[3:0])
      CC_STATUS: code_ok = 1'b1;
      CC_RD_LOCK, CC_RD_DATA: code_ok = slave_tx_enable & lock_ok;
      CC_LKA_LO, CC_LKA_HI: code_ok = locked;
      CC_STAT_UNLK: code_ok = lock_ok;
      CC_WC_LOCK, CC_WD_LOCK, CC_WR_CMD, CC_WR_DATA: begin
        code_ok = slave_rx_enable & lock_ok;
      end
      default: code_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Field sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_field = field_ff;
    nxt_pos = pos_ff;
    nxt_pty = pty_ff;
    nxt_ok = ok_ff;
    nxt_ack = ack_ff;
    nxt_dir_wr = dir_wr_ff;
    nxt_bcast = bcast_ff;
    nxt_sr = sr_ff;
    nxt_tx = tx_ff;
    nxt_buf = buf_ff;
    nxt_left = left_ff;
    full_set = 1'b0;
    nxt_req = 1'b0;
    nxt_end = 1'b0;
    if (!link.frame) begin
      nxt_field = FLD_IDLE;
    end else if (start) begin
      // Untargeted individual traffic is not followed at all.
      nxt_field = (broadcast_flag | targeted_request_flag) ?
                  FLD_CTRL : FLD_HALT;
      nxt_bcast = broadcast_flag;
      nxt_pos = 4'h0;
      nxt_pty = 1'b0;
    end else if (link.sync && live) begin
      nxt_pos = pos_ff + 4'd1;
      if (at_data) begin
        nxt_pty = pty_ff ^ bit_in;
        nxt_sr = {sr_ff[6:0], bit_in};
      end else if (at_par) begin
        unique case (field_ff)
          FLD_CTRL: nxt_ok = ctrl_ack | bc_go;
          FLD_LEN: nxt_ok = rx_ok;
          default: nxt_ok = take;
        endcase
        nxt_ack = (nxt_ok & ~i_send) ? ACK : NACK;
      end else begin
        nxt_pos = 4'h0;
        nxt_pty = 1'b0;
        unique case (field_ff)
          FLD_CTRL: begin
            nxt_dir_wr = sr_ff[3];
            nxt_tx = tx_len;
            nxt_field = ok_ff ? FLD_LEN : FLD_HALT;
          end
          FLD_LEN: begin
            if (dir_wr_ff) begin
              nxt_left = sfa_len_count(sr_ff);
              nxt_field = ok_ff ? FLD_DATA : FLD_HALT;
            end else begin
              nxt_left = sfa_len_count(tx_ff);
              nxt_tx = tx_data;
              nxt_field = (bit_in == ACK) ? FLD_DATA : FLD_HALT;
            end
          end
          default: begin
            if (dir_wr_ff) begin
              if (ok_ff) begin
                nxt_buf = sr_ff;
                full_set = 1'b1;
                nxt_left = left_ff - 9'd1;
                nxt_req = 1'b1;
                nxt_end = last;
                nxt_field = last ? FLD_HALT : FLD_DATA;
              end else if (bcast_ff) begin
                nxt_field = FLD_HALT;
              end
            end else if (bit_in == ACK) begin
              nxt_left = left_ff - 9'd1;
              nxt_tx = tx_data;
              nxt_req = 1'b1;
              nxt_end = last;
              nxt_field = last ? FLD_HALT : FLD_DATA;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      field_ff <= FLD_IDLE;
      pos_ff <= 4'h0;
      pty_ff <= 1'b0;
      ok_ff <= 1'b0;
      ack_ff <= NACK;
      dir_wr_ff <= 1'b0;
      bcast_ff <= 1'b0;
      sr_ff <= 8'h00;
      tx_ff <= 8'h00;
      buf_ff <= 8'h00;
      left_ff <= 9'h000;
      req_ff <= 1'b0;
      end_ff <= 1'b0;
      frame_d_ff <= 1'b0;
      full_ff <= 1'b0;
      s_o_ff <= 1'b1;
      s_oe_ff <= 1'b0;
    end else begin
      field_ff <= nxt_field;
      pos_ff <= nxt_pos;
      pty_ff <= nxt_pty;
      ok_ff <= nxt_ok;
      ack_ff <= nxt_ack;
      dir_wr_ff <= nxt_dir_wr;
      bcast_ff <= nxt_bcast;
      sr_ff <= nxt_sr;
      tx_ff <= nxt_tx;
      buf_ff <= nxt_buf;
      left_ff <= nxt_left;
      req_ff <= nxt_req;
      end_ff <= nxt_end;
      frame_d_ff <= link.frame;
      full_ff <= full_set | (full_ff & ~rx_taken);
      s_o_ff <= drv_data ? drv_bit : ack_ff;
      s_oe_ff <= drv_data | drv_ack;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.s_o = s_o_ff;
  assign link.s_oe = s_oe_ff;
  assign byte_buffer = buf_ff;
  assign rx_full = full_ff;
  assign data_request_irq = req_ff;
  assign transfer_end_irq = end_ff;

endmodule

// file: sfa_master_end.sv
module sfa_master_end #(
  parameter int MAX_TRIES = 32
) (
  sfa_link_if.master link,
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import sfa_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sfa_field_e field_ff, nxt_field;
  logic [3:0] pos_ff, nxt_pos;
  logic [2:0] tick_ff, nxt_tick;
  logic pty_ff, nxt_pty, ok_ff, nxt_ok, ack_ff, nxt_ack;
  logic dir_wr_ff, nxt_dir_wr, bcast_ff, nxt_bcast;
  logic need_ff, nxt_need, frame_ff, nxt_frame;
  sfa_byte_t sr_ff, nxt_sr, tx_ff, nxt_tx, rxb_ff, nxt_rxb;
  logic [8:0] left_ff, nxt_left;
  logic [15:0] tries_ff, nxt_tries;
  logic rx_set, tx_load, fin_ok, fin_bad;
  sfa_code_t code_ff;
  sfa_byte_t len_cfg_ff, txb_ff;
  logic bc_cfg_ff, txf_ff, rxf_ff, done_ff, nack_ff, refuse_ff;
  logic rd_ok_ff, m_o_ff, m_oe_ff;
  logic [31:0] rdata_ff;

  // ---------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------
  wire wr_ctrl = avs_write & (avs_address == REG_CTRL);
  wire wr_txd = avs_write & (avs_address == REG_TXD) & avs_byteenable[0];
  wire rd_first = avs_read & ~rd_ok_ff;
  wire rd_rxd = avs_read & rd_ok_ff & (avs_address == REG_RXD);
  wire be0 = wr_ctrl & avs_byteenable[0];
  wire be1 = wr_ctrl & avs_byteenable[1];
  wire [3:0] new_code = be0 ? avs_writedata[3:0] : code_ff;
  wire new_bc = be0 ? avs_writedata[CTRL_BCAST_BIT] : bc_cfg_ff;
  wire sfa_byte_t new_len = be1 ? avs_writedata[15:8] : len_cfg_ff;
  wire go = wr_ctrl & avs_byteenable[2] & avs_writedata[CTRL_GO_BIT] &
            (field_ff == FLD_IDLE);
  wire bad_rd = new_bc & ~new_code[3];
  wire start = go & ~bad_rd;
  wire [31:0] rmux =
    (avs_address == REG_CTRL) ? {16'h0000, len_cfg_ff, 3'h0, bc_cfg_ff,
                                 code_ff} :
    (avs_address == REG_RXD) ? {24'h000000, rxb_ff} :
    (avs_address == REG_STAT) ? {26'h0000000, refuse_ff, nack_ff, done_ff,
                                 rxf_ff, txf_ff, frame_ff} : 32'h00000000;

  // ---------------------------------------------------------------
  // Link decode
  // ---------------------------------------------------------------
  wire live = (field_ff != FLD_IDLE) && (field_ff != FLD_HALT);
  wire [3:0] fw = (field_ff == FLD_CTRL) ? CTRL_W : BYTE_W;
  wire at_data = pos_ff < fw;
  wire at_par = pos_ff == fw;
  wire at_ack = pos_ff == (fw + 4'd1);
  wire m_send = (field_ff == FLD_CTRL) | dir_wr_ff;
  wire hold = (field_ff == FLD_DATA) & need_ff;
  wire sync = live & ~hold & (tick_ff == TICK_LAST);
  wire bit_in = link.line;
  wire pty_ok = ~(pty_ff ^ bit_in);
  wire got_ack = bcast_ff | (bit_in == ACK);
  wire last = left_ff == LEFT_ONE;
  wire limit = (tries_ff + 16'd1) >= 16'(MAX_TRIES);
  wire [2:0] bit_ix = 3'(fw - 4'd1 - pos_ff);
  wire drv_oe = live & ((m_send & ~at_ack) | (~m_send & at_ack));
  wire drv_bit = at_data ? tx_ff[bit_ix] : (at_par ? ^tx_ff : ack_ff);

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_field = field_ff;
    nxt_pos = pos_ff;
    nxt_tick = live & ~hold ? 3'(tick_ff + 3'd1) : 3'h0;
    nxt_pty = pty_ff;
    nxt_ok = ok_ff;
    nxt_ack = ack_ff;
    nxt_dir_wr = dir_wr_ff;
    nxt_bcast = bcast_ff;
    nxt_need = need_ff;
    nxt_frame = frame_ff;
    nxt_sr = sr_ff;
    nxt_tx = tx_ff;
    nxt_rxb = rxb_ff;
    nxt_left = left_ff;
    nxt_tries = tries_ff;
    rx_set = 1'b0;
    tx_load = 1'b0;
    fin_ok = 1'b0;
    fin_bad = 1'b0;
    if (sync && tick_ff == TICK_LAST) begin
      nxt_tick = 3'h0;
    end
    if (start) begin
      nxt_field = FLD_CTRL;
      nxt_frame = 1'b1;
      nxt_pos = 4'h0;
      nxt_pty = 1'b0;
      nxt_tick = 3'h0;
      nxt_bcast = new_bc;
      nxt_dir_wr = new_code[3];
      nxt_tx = {4'h0, new_code};
      nxt_tries = 16'h0000;
    end else if (hold && txf_ff) begin
      nxt_tx = txb_ff;
      nxt_need = 1'b0;
      tx_load = 1'b1;
    end else if (sync) begin
      nxt_pos = pos_ff + 4'd1;
      if (at_data) begin
        nxt_pty = pty_ff ^ bit_in;
        nxt_sr = {sr_ff[6:0], bit_in};
      end else if (at_par) begin
        nxt_ok = (field_ff == FLD_DATA) ? pty_ok & ~rxf_ff : pty_ok;
        nxt_ack = nxt_ok ? ACK : NACK;
      end else begin
        nxt_pos = 4'h0;
        nxt_pty = 1'b0;
        unique case (field_ff)
          FLD_CTRL: begin
            nxt_tx = len_cfg_ff;
            nxt_field = FLD_LEN;
            fin_bad = ~got_ack;
          end
          FLD_LEN: begin
            nxt_left = sfa_len_count(dir_wr_ff ? tx_ff : sr_ff);
            nxt_need = dir_wr_ff;
            nxt_field = FLD_DATA;
            fin_bad = dir_wr_ff ? ~got_ack : ~ok_ff;
          end
          default: begin
            nxt_tries = tries_ff + 16'd1;
            if (dir_wr_ff ? got_ack : ok_ff) begin
              nxt_left = left_ff - 9'd1;
              nxt_need = dir_wr_ff & ~last;
              nxt_rxb = dir_wr_ff ? rxb_ff : sr_ff;
              rx_set = ~dir_wr_ff;
              fin_ok = last;
              fin_bad = ~last & limit;
            end else begin
              fin_bad = limit;
            end
          end
        endcase
      end
    end
    if (fin_ok | fin_bad) begin
      nxt_field = FLD_IDLE;
      nxt_frame = 1'b0;
      nxt_need = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      field_ff <= FLD_IDLE;
      pos_ff <= 4'h0;
      tick_ff <= 3'h0;
      pty_ff <= 1'b0;
      ok_ff <= 1'b0;
      ack_ff <= NACK;
      dir_wr_ff <= 1'b0;
      bcast_ff <= 1'b0;
      need_ff <= 1'b0;
      frame_ff <= 1'b0;
      sr_ff <= 8'h00;
      tx_ff <= 8'h00;
      rxb_ff <= 8'h00;
      left_ff <= 9'h000;
      tries_ff <= 16'h0000;
      code_ff <= 4'h0;
      len_cfg_ff <= 8'h00;
      txb_ff <= 8'h00;
      bc_cfg_ff <= 1'b0;
      txf_ff <= 1'b0;
      rxf_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      refuse_ff <= 1'b0;
      rd_ok_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      m_o_ff <= 1'b1;
      m_oe_ff <= 1'b0;
    end else begin
      field_ff <= nxt_field;
      pos_ff <= nxt_pos;
      tick_ff <= nxt_tick;
      pty_ff <= nxt_pty;
      ok_ff <= nxt_ok;
      ack_ff <= nxt_ack;
      dir_wr_ff <= nxt_dir_wr;
      bcast_ff <= nxt_bcast;
      need_ff <= nxt_need;
      frame_ff <= nxt_frame;
      sr_ff <= nxt_sr;
      tx_ff <= nxt_tx;
      rxb_ff <= nxt_rxb;
      left_ff <= nxt_left;
      tries_ff <= nxt_tries;
      code_ff <= new_code;
      len_cfg_ff <= new_len;
      bc_cfg_ff <= new_bc;
      txb_ff <= wr_txd ? avs_writedata[7:0] : txb_ff;
      txf_ff <= wr_txd | (txf_ff & ~tx_load);
      rxf_ff <= rx_set | (rxf_ff & ~rd_rxd);
      done_ff <= fin_ok | (done_ff & ~start);
      nack_ff <= fin_bad | (nack_ff & ~start);
      refuse_ff <= (go & bad_rd) | (refuse_ff & ~start);
      rd_ok_ff <= rd_first;
      rdata_ff <= rd_first ? rmux : rdata_ff;
      m_o_ff <= drv_bit;
      m_oe_ff <= drv_oe;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.frame = frame_ff;
  assign link.sync = sync;
  assign link.m_o = m_o_ff;
  assign link.m_oe = m_oe_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = avs_read & ~rd_ok_ff;

endmodule

// file: sfa_link_properties.sv
module sfa_link_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic frame,
  input wire logic sync,
  input wire logic m_o,
  input wire logic m_oe,
  input wire logic s_o,
  input wire logic s_oe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Running parity of the control bits.
  // ---------------------------------------------------------------
  logic [3:0] nsync_ff;
  logic par_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nsync_ff <= 4'h0;
      par_ff <= 1'b0;
    end else if (!frame) begin
      nsync_ff <= 4'h0;
      par_ff <= 1'b0;
    end else if (sync && nsync_ff != 4'hF) begin
      nsync_ff <= nsync_ff + 4'h1;
      par_ff <= par_ff ^ line;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  AST_IDLE_NO_SYNC: assert property (!frame |-> !sync)
    else $error("sync outside a frame");
  AST_SYNC_SPACING: assert property (sync |=> !sync [*3])
    else $error("sync pulses too close");
  AST_FIRST_SYNC: assert property ($rose(frame) |-> ##[1:8] sync)
    else $error("no first bit after frame start");
  AST_ONE_DRIVER: assert property (sync |-> !(m_oe && s_oe))
    else $error("both ends drive one bit slot");
  AST_LINE_SETTLED: assert property (frame && sync |-> $stable(line))
    else $error("line moved just before sampling");
  AST_SLAVE_ON_SYNC: assert property (
    frame && $past(frame) && $changed(s_o) |-> $past(sync, 2))
    else $error("slave bit changed without a sync");
  AST_RELEASE: assert property ($fell(frame) |=> ##1 (!m_oe && !s_oe))
    else $error("line still driven after frame end");
  AST_CTRL_PARITY: assert property (
    frame && sync && nsync_ff == 4'h4 |-> line == par_ff)
    else $error("control parity bit not even");

  cover property ($rose(frame));
  cover property (sync && s_oe);
  cover property ($fell(frame));
endmodule

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sfa_pkg::*;

  logic mclk, rst, avs_read, avs_write, rx_taken;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, s;
  logic avs_waitrequest, a;
  logic broadcast_flag, targeted_request_flag, locked, lock_owner_match;
  logic slave_tx_enable, slave_rx_enable;
  logic timing_error, rx_full, data_request_irq, transfer_end_irq;
  sfa_byte_t tx_len, tx_data, byte_buffer;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int n_req = 0;
  int n_end = 0;
  logic [4:0] cfg [5] = '{5'b10001, 5'b10010, 5'b11011, 5'b11101,
                          5'b00011};

  sfa_link_if link ();
  sfa_master_end #(.MAX_TRIES(300)) sfa_master_end_inst (.link(link),
    .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest);
  sfa_slave_end sfa_slave_end_inst (.link(link), .mclk, .rst,
    .broadcast_flag, .targeted_request_flag, .locked, .lock_owner_match,
    .slave_tx_enable, .slave_rx_enable, .timing_error, .tx_len,
    .tx_data, .rx_taken, .byte_buffer, .rx_full, .data_request_irq,
    .transfer_end_irq);
  sfa_link_checker sfa_link_checker_inst (.mclk, .rst,
    .frame(link.frame), .sync(link.sync), .m_o(link.m_o),
    .m_oe(link.m_oe), .s_o(link.s_o), .s_oe(link.s_oe),
    .line(link.line));

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
           output logic [31:0] r);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= d;
    @(posedge mclk iff !avs_waitrequest);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task go(input logic [3:0] c, input logic b, input sfa_byte_t len);
    bus(1'b1, REG_CTRL, {15'h0, 1'b1, len, 3'h0, b, c}, q);
  endtask

  task idle();
    do bus(1'b0, REG_STAT, 32'h0, s); while (s[0] !== 1'b0);
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic ack_of(input logic [3:0] c,
                                  input logic [4:0] k);
    logic t, l, o, x, r;
    {t, l, o, x, r} = k;
    case (c)
      4'h0: ack_of = t;
      4'h3, 4'h7: ack_of = t & x & (!l | o);
      4'h4, 4'h5: ack_of = t & l;
      4'h6: ack_of = t & (!l | o);
      4'hA, 4'hB, 4'hE, 4'hF: ack_of = t & r & (!l | o);
      default: ack_of = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Clock, timeout and tests
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (data_request_irq === 1'b1) n_req++;
    if (transfer_end_irq === 1'b1) n_end++;
    if (cyc == 90000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    rst = 1'b1;
    {broadcast_flag, targeted_request_flag, locked} = 3'b0;
    {lock_owner_match, slave_tx_enable, slave_rx_enable} = 3'b0;
    timing_error = 1'b0;
    {tx_len, tx_data, rx_taken} = {8'h01, 8'h96, 1'b1};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      {targeted_request_flag, locked, lock_owner_match, slave_tx_enable,
       slave_rx_enable} <= cfg[i];
      for (int c = 0; c < 16; c++) begin
        a = ack_of(4'(c), cfg[i]);
        if (a && c[3]) bus(1'b1, REG_TXD, {24'h0, 4'(c), 4'(i)}, q);
        go(4'(c), 1'b0, 8'h01);
        idle();
        chk(s[4], !a);
        if (a && c[3]) chk(byte_buffer, {4'(c), 4'(i)});
        if (a && !c[3]) begin
          bus(1'b0, REG_RXD, 32'h0, q);
          chk(q[7:0], 8'h96);
        end
      end
    end
    $display("test ack table done");
    {broadcast_flag, targeted_request_flag, slave_rx_enable} <= 3'b100;
    locked <= 1'b0;
    bus(1'b1, REG_TXD, 32'hC3, q);
    go(4'hF, 1'b1, 8'h01);
    idle();
    chk(byte_buffer, 8'hC3);
    go(4'h7, 1'b1, 8'h01);
    bus(1'b0, REG_STAT, 32'h0, s);
    chk(s[5], 1'b1);
    chk(link.frame, 1'b0);
    $display("test broadcast done");
    {broadcast_flag, targeted_request_flag, slave_rx_enable} <= 3'b011;
    rx_taken <= 1'b0;
    timing_error <= 1'b1;
    go(4'h0, 1'b0, 8'h01);
    idle();
    chk(s[4], 1'b1);
    timing_error <= 1'b0;
    bus(1'b1, REG_TXD, 32'h11, q);
    go(4'hF, 1'b0, 8'h02);
    do bus(1'b0, REG_STAT, 32'h0, s); while (s[1] !== 1'b0);
    bus(1'b1, REG_TXD, 32'h22, q);
    idle();
    chk(byte_buffer, 8'h11);
    chk(s[4], 1'b1);
    chk(rx_full, 1'b1);
    $display("test retry limit done");
    rx_taken <= 1'b1;
    slave_tx_enable <= 1'b1;
    tx_len <= 8'h00;
    n_req = 0;
    n_end = 0;
    go(4'h7, 1'b0, 8'h01);
    n = 0;
    while (1) begin
      bus(1'b0, REG_STAT, 32'h0, s);
      if (s[2] === 1'b1) begin
        bus(1'b0, REG_RXD, 32'h0, q);
        n++;
      end
      if (s[0] === 1'b0 && s[2] === 1'b0) break;
    end
    chk(n, 256);
    chk(s[4], 1'b0);
    chk(n_req, 256);
    chk(n_end, 1);
    $display("test long read done");
    report_and_stop();
  end
endmodule
